// ===== fcb_bank.sv
// floppy controller configuration bank and runtime register window
// assumes decoded host I/O and configuration strobes on clk, one cycle each
`timescale 1ns/100ps
module fcb_bank
  import fcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host I/O cycles into the runtime window
  input wire fcb_pkg::fcb_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic io_claim,
  // configuration index cycles for this logical device
  input wire fcb_pkg::fcb_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // global enables from the system configuration block
  input wire logic global_config_one_en,
  input wire logic global_config_six_en,
  // command engine side
  input wire logic wgate_req,
  output logic double_density_mode,
  output logic write_protected,
  // drive pins; inputs active low, asynchronous; outputs registered
  input wire logic index_n_pin,
  input wire logic track0_n_pin,
  input wire logic wp_n_pin,
  input wire logic dskchg_n_pin,
  output fcb_pkg::fcb_pins_t pins_o,
  output fcb_pkg::fcb_pins_t pins_oe
);
  import fcb_pkg::*;

  logic [7:0] activate_q, base_hi_q, base_lo_q, int_num_q, int_type_q;
  logic [7:0] dma_sel_q, ctrl_cfg_q, drive_identification_q;
  logic [7:0] dig_out_q, tape_q, rate_q, queue_q, cctl_q;
  logic [3:0] pin_sync;
  logic active, hit, hiz, high_rate, wp_active;
  logic [7:0] tape_rd, io_rd_d, cfg_rd_d;
  logic [1:0] sel_id;
  fcb_cmd_t cmd_q;
  fcb_pins_t want;

  // only these four drive inputs exist; there is no media sense
  fcb_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({index_n_pin, track0_n_pin, wp_n_pin, dskchg_n_pin}),
    .sync(pin_sync)
  );

  assign active = activate_q[0] & global_config_one_en
                  & global_config_six_en;
  // the window is eight bytes; base low bits 2:0 never take part
  assign hit = active && io_req.addr[15:3]
               == {5'h00, base_hi_q[2:0], base_lo_q[7:3]};

  // configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      activate_q <= FCB_RST_ACTIVATE;
      base_hi_q <= FCB_RST_BASE_HI;
      base_lo_q <= FCB_RST_BASE_LO;
      int_num_q <= FCB_RST_INT_NUM;
      int_type_q <= FCB_RST_INT_TYPE;
      dma_sel_q <= FCB_RST_DMA_SEL;
      ctrl_cfg_q <= FCB_RST_CTRL_CFG;
      drive_identification_q <= FCB_RST_DRIVE_IDENTIFICATION;
    end else if (cfg_req.wr) begin
      case (cfg_req.index)
        FCB_IDX_ACTIVATE: activate_q <= cfg_req.wdata;
        FCB_IDX_BASE_HI: begin
          base_hi_q <= cfg_req.wdata & FCB_WMASK_BASE_HI;
        end
        FCB_IDX_BASE_LO: begin
          base_lo_q <= cfg_req.wdata & FCB_WMASK_BASE_LO;
        end
        FCB_IDX_INT_NUM: int_num_q <= cfg_req.wdata;
        FCB_IDX_INT_TYPE: begin
          int_type_q <= (int_type_q & ~FCB_WMASK_INT_TYPE)
                        | (cfg_req.wdata & FCB_WMASK_INT_TYPE);
        end
        FCB_IDX_DMA_SEL: dma_sel_q <= cfg_req.wdata;
        FCB_IDX_CTRL_CFG: begin
          // reserved bits are held at zero in case software ignores them
          ctrl_cfg_q <= cfg_req.wdata & FCB_WMASK_CTRL_CFG;
        end
        FCB_IDX_DRIVE_IDENTIFICATION: drive_identification_q <= cfg_req.wdata;
        default: ;
      endcase
    end
  end

  // configuration read path
  always_comb begin
    case (cfg_req.index)
      FCB_IDX_ACTIVATE: cfg_rd_d = activate_q;
      FCB_IDX_BASE_HI: cfg_rd_d = base_hi_q;
      FCB_IDX_BASE_LO: cfg_rd_d = base_lo_q;
      FCB_IDX_INT_NUM: cfg_rd_d = int_num_q;
      FCB_IDX_INT_TYPE: cfg_rd_d = int_type_q;
      FCB_IDX_DMA_SEL: cfg_rd_d = dma_sel_q;
      FCB_IDX_DMA2_RPT: cfg_rd_d = FCB_VAL_DMA2_RPT;
      FCB_IDX_CTRL_CFG: cfg_rd_d = ctrl_cfg_q;
      FCB_IDX_DRIVE_IDENTIFICATION: cfg_rd_d = drive_identification_q;
      default: cfg_rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata <= cfg_req.rd ? cfg_rd_d : 8'h00;
      cfg_rvalid <= cfg_req.rd;
    end
  end

  // runtime writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dig_out_q <= FCB_RST_DIG_OUT;
      tape_q <= 8'h00;
      rate_q <= FCB_RST_RATE;
      cctl_q <= FCB_RST_RATE;
      queue_q <= 8'h00;
    end else if (io_req.wr && hit) begin
      case (io_req.addr[2:0])
        FCB_OFS_DIG_OUT: dig_out_q <= io_req.wdata;
        FCB_OFS_TAPE: tape_q <= io_req.wdata;
        FCB_OFS_MAIN_RATE: rate_q <= io_req.wdata;
        FCB_OFS_QUEUE: queue_q <= io_req.wdata;
        FCB_OFS_DIN_CCTL: cctl_q <= io_req.wdata;
        default: ;
      endcase
    end
  end

  // first command byte carries the recording mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q <= FCB_CMD_IDLE;
      double_density_mode <= 1'b0;
    end else begin
      case (cmd_q)
        FCB_CMD_IDLE: begin
          if (io_req.wr && hit && io_req.addr[2:0] == FCB_OFS_QUEUE) begin
            double_density_mode <= io_req.wdata[FCB_CMD_MODE_BIT];
            cmd_q <= FCB_CMD_BUSY;
          end
        end
        FCB_CMD_BUSY: begin
          // a result read or a drive reset ends the command
          if ((io_req.rd && hit && io_req.addr[2:0] == FCB_OFS_QUEUE)
              || !dig_out_q[2]) begin
            cmd_q <= FCB_CMD_IDLE;
          end
        end
        default: cmd_q <= FCB_CMD_IDLE;
      endcase
    end
  end

  // tape register view depends on the mode bit
  assign sel_id = dig_out_q[0] ? drive_identification_q[3:2] : drive_identification_q[1:0];
  always_comb begin
    if (!ctrl_cfg_q[FCB_CFG_TAPE_MODE]) begin
      tape_rd = {6'h3F, tape_q[1:0]};
    end else begin
      tape_rd = {2'h3, sel_id, 2'h3, tape_q[1:0]};
    end
  end

  // runtime read path; undriven bits read as one
  always_comb begin
    case (io_req.addr[2:0])
      FCB_OFS_STATUS_A: io_rd_d = {FCB_FLOAT[7:4], pin_sync[3],
                                   pin_sync[2], pin_sync[1],
                                   dig_out_q[0]};
      FCB_OFS_STATUS_B: io_rd_d = {FCB_FLOAT[7:4], dig_out_q[5:4],
                                   dig_out_q[0], ~wgate_req};
      FCB_OFS_DIG_OUT: io_rd_d = dig_out_q;
      FCB_OFS_TAPE: io_rd_d = tape_rd;
      FCB_OFS_MAIN_RATE: begin
        io_rd_d = (cmd_q == FCB_CMD_BUSY) ? FCB_MAIN_BUSY
                                          : FCB_MAIN_READY;
      end
      FCB_OFS_QUEUE: io_rd_d = queue_q;
      FCB_OFS_DIN_CCTL: begin
        // alternate drive mode inverts the change line; the other mode shows the rate
        if (ctrl_cfg_q[FCB_CFG_LEGACY_DRV]) begin
          io_rd_d = {~pin_sync[0], FCB_FLOAT[6:0]};
        end else begin
          io_rd_d = {pin_sync[0], FCB_FLOAT[6:3], cctl_q[1:0],
                     ~high_rate};
        end
      end
      default: io_rd_d = FCB_FLOAT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata <= FCB_FLOAT;
      io_rvalid <= 1'b0;
      io_claim <= 1'b0;
    end else begin
      io_rdata <= (io_req.rd && hit) ? io_rd_d : FCB_FLOAT;
      io_rvalid <= io_req.rd && hit;
      io_claim <= (io_req.rd || io_req.wr) && hit;
    end
  end

  // drive pins
  assign high_rate = (cctl_q[1:0] == FCB_RATE_500K)
                     || (cctl_q[1:0] == FCB_RATE_1M);
  assign wp_active = !pin_sync[1] || ctrl_cfg_q[FCB_CFG_FORCE_WP];
  assign hiz = ctrl_cfg_q[FCB_CFG_HIZ_CTL] && !active;

  always_comb begin
    want.drive_sel_n[0] = !(dig_out_q[4] && !dig_out_q[0]);
    want.drive_sel_n[1] = !(dig_out_q[5] && dig_out_q[0]);
    want.motor_n = ~dig_out_q[5:4];
    want.density_select_out = ctrl_cfg_q[FCB_CFG_DENS_POL] ? high_rate
                                                           : !high_rate;
    want.write_gate_n = !(wgate_req && !wp_active);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_protected <= 1'b0;
    end else begin
      write_protected <= wp_active;
    end
  end

  // upper rate output is not provided
  fcb_pin_drv u_drv (
    .clk(clk),
    .rst(rst),
    .want(want),
    .hiz(hiz),
    .pin_o(pins_o),
    .pin_oe(pins_oe)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tape_legacy;
    io_rvalid && $past(io_req.addr[2:0]) == FCB_OFS_TAPE
    && !$past(ctrl_cfg_q[FCB_CFG_TAPE_MODE]) |-> io_rdata[7:2] == 6'h3F;
  endproperty
  a_tape_legacy: assert property (p_tape_legacy)
    else $error("tape register upper bits not all ones in legacy mode");

  property p_force_wp;
    ctrl_cfg_q[FCB_CFG_FORCE_WP] && wgate_req |=> pins_o.write_gate_n;
  endproperty
  a_force_wp: assert property (p_force_wp)
    else $error("write gate asserted while write protect forced");

  property p_hiz;
    ctrl_cfg_q[FCB_CFG_HIZ_CTL] && !active |=> pins_oe == '0;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("outputs driven while inactive with float enabled");

  property p_density;
    high_rate |=> pins_o.density_select_out
                  == $past(ctrl_cfg_q[FCB_CFG_DENS_POL]);
  endproperty
  a_density: assert property (p_density)
    else $error("density select polarity wrong at high rate");

  property p_unused;
    io_req.rd && hit && io_req.addr[2:0] == FCB_OFS_UNUSED
    |=> io_rvalid && io_rdata == FCB_FLOAT;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused offset did not read all ones");

  property p_base_ro;
    base_hi_q[7:3] == 5'h00 && {base_lo_q[2], base_lo_q[0]} == 2'h0;
  endproperty
  a_base_ro: assert property (p_base_ro)
    else $error("base address read only bits nonzero");

  property p_int_type;
    cfg_req.wr && cfg_req.index == FCB_IDX_INT_TYPE
    |=> int_type_q[7:2] == $past(int_type_q[7:2])
        && int_type_q[0] == $past(int_type_q[0]);
  endproperty
  a_int_type: assert property (p_int_type)
    else $error("read only interrupt type bit changed");

  property p_cmd_mode;
    cmd_q == FCB_CMD_IDLE && io_req.wr && hit
    && io_req.addr[2:0] == FCB_OFS_QUEUE
    |=> double_density_mode == $past(io_req.wdata[FCB_CMD_MODE_BIT]);
  endproperty
  a_cmd_mode: assert property (p_cmd_mode)
    else $error("recording mode not taken from first command byte");

  property p_inactive;
    !active && (io_req.rd || io_req.wr) |=> !io_claim ##1 1'b1;
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("window claimed while device inactive");

  property p_tape_enhanced;
    io_rvalid && $past(io_req.addr[2:0]) == FCB_OFS_TAPE
    && $past(ctrl_cfg_q[FCB_CFG_TAPE_MODE])
    |-> io_rdata[5:4] == $past(dig_out_q[0] ? drive_identification_q[3:2]
                                             : drive_identification_q[1:0]);
  endproperty
  a_tape_enhanced: assert property (p_tape_enhanced)
    else $error("tape register does not show the selected drive_identification");

  property p_dma2_rpt;
    cfg_req.rd && cfg_req.index == FCB_IDX_DMA2_RPT
    |=> cfg_rvalid && cfg_rdata == FCB_VAL_DMA2_RPT;
  endproperty
  a_dma2_rpt: assert property (p_dma2_rpt)
    else $error("second DMA report did not read its fixed value");
endmodule

// ===== fcb_host_model.sv
// host side model issuing single-byte I/O and configuration cycles
// assumes the bank answers on the edge that takes a strobe
`timescale 1ns/100ps
module fcb_host_model
  import fcb_pkg::*;
(
  // clock
  input wire logic clk,
  // requests out
  output fcb_pkg::fcb_io_req_t io_req,
  output fcb_pkg::fcb_cfg_req_t cfg_req,
  // answers in
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic io_claim,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  initial begin
    io_req = '0;
    cfg_req = '0;
  end

  // released lines show the inverse so a stale value never looks valid
  task automatic io_cyc(input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic hit);
    @(negedge clk);
    io_req.rd = !w;
    io_req.wr = w;
    io_req.addr = a;
    io_req.wdata = d;
    @(negedge clk);
    q = io_rdata;
    hit = io_claim & (w | io_rvalid);
    io_req.rd = 1'b0;
    io_req.wr = 1'b0;
    io_req.addr = ~a;
    io_req.wdata = ~d;
  endtask

  task automatic cfg_cyc(input logic w, input logic [7:0] i,
      input logic [7:0] d, output logic [7:0] q, output logic v);
    @(negedge clk);
    cfg_req.rd = !w;
    cfg_req.wr = w;
    cfg_req.index = i;
    cfg_req.wdata = (i == FCB_IDX_CTRL_CFG) ? (d & 8'h6F) : d;
    @(negedge clk);
    q = cfg_rdata;
    v = cfg_rvalid;
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b0;
    cfg_req.index = ~i;
    cfg_req.wdata = ~d;
  endtask
endmodule

// ===== fcb_pin_drv.sv
// registered drive pins with output enables
// assumes the caller resolves the pad level from the enables
`timescale 1ns/100ps
module fcb_pin_drv
  import fcb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wanted pin levels and the high impedance request
  input wire fcb_pkg::fcb_pins_t want,
  input wire logic hiz,
  // pads
  output fcb_pkg::fcb_pins_t pin_o,
  output fcb_pkg::fcb_pins_t pin_oe
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_o <= '1;
      pin_oe <= '0;
    end else begin
      pin_o <= want;
      pin_oe <= hiz ? '0 : '1;
    end
  end
endmodule

// ===== fcb_pkg.sv
// constants and carrier types for the floppy controller configuration bank
// assumes one 200 MHz clock shared with the host bus decode logic
package fcb_pkg;
  // runtime window offsets (low three address bits)
  localparam logic [2:0] FCB_OFS_STATUS_A = 3'h0;
  localparam logic [2:0] FCB_OFS_STATUS_B = 3'h1;
  localparam logic [2:0] FCB_OFS_DIG_OUT = 3'h2;
  localparam logic [2:0] FCB_OFS_TAPE = 3'h3;
  localparam logic [2:0] FCB_OFS_MAIN_RATE = 3'h4;
  localparam logic [2:0] FCB_OFS_QUEUE = 3'h5;
  localparam logic [2:0] FCB_OFS_UNUSED = 3'h6;
  localparam logic [2:0] FCB_OFS_DIN_CCTL = 3'h7;
  // configuration indexes
  localparam logic [7:0] FCB_IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] FCB_IDX_BASE_HI = 8'h60;
  localparam logic [7:0] FCB_IDX_BASE_LO = 8'h61;
  localparam logic [7:0] FCB_IDX_INT_NUM = 8'h70;
  localparam logic [7:0] FCB_IDX_INT_TYPE = 8'h71;
  localparam logic [7:0] FCB_IDX_DMA_SEL = 8'h74;
  localparam logic [7:0] FCB_IDX_DMA2_RPT = 8'h75;
  localparam logic [7:0] FCB_IDX_CTRL_CFG = 8'hF0;
  localparam logic [7:0] FCB_IDX_DRIVE_IDENTIFICATION = 8'hF1;
  // reset values
  localparam logic [7:0] FCB_RST_ACTIVATE = 8'h00;
  localparam logic [7:0] FCB_RST_BASE_HI = 8'h03;
  localparam logic [7:0] FCB_RST_BASE_LO = 8'hF2;
  localparam logic [7:0] FCB_RST_INT_NUM = 8'h06;
  localparam logic [7:0] FCB_RST_INT_TYPE = 8'h03;
  localparam logic [7:0] FCB_RST_DMA_SEL = 8'h02;
  localparam logic [7:0] FCB_VAL_DMA2_RPT = 8'h04;
  localparam logic [7:0] FCB_RST_CTRL_CFG = 8'h24;
  localparam logic [7:0] FCB_RST_DRIVE_IDENTIFICATION = 8'h00;
  localparam logic [7:0] FCB_RST_DIG_OUT = 8'h00;
  localparam logic [7:0] FCB_RST_RATE = 8'h02;
  // writable masks and the all-ones float value
  localparam logic [7:0] FCB_WMASK_BASE_HI = 8'h07;
  localparam logic [7:0] FCB_WMASK_BASE_LO = 8'hFA;
  localparam logic [7:0] FCB_WMASK_INT_TYPE = 8'h02;
  localparam logic [7:0] FCB_WMASK_CTRL_CFG = 8'h6F;
  localparam logic [7:0] FCB_FLOAT = 8'hFF;
  // controller configuration bit positions
  localparam int FCB_CFG_TAPE_MODE = 6;
  localparam int FCB_CFG_DENS_POL = 5;
  localparam int FCB_CFG_FORCE_WP = 3;
  localparam int FCB_CFG_LEGACY_DRV = 2;
  localparam int FCB_CFG_HIZ_CTL = 0;
  // command byte recording mode bit
  localparam int FCB_CMD_MODE_BIT = 6;
  // data rate codes that assert density select
  localparam logic [1:0] FCB_RATE_500K = 2'h0;
  localparam logic [1:0] FCB_RATE_1M = 2'h3;
  // main status: request for master, host may transfer
  localparam logic [7:0] FCB_MAIN_READY = 8'h80;
  localparam logic [7:0] FCB_MAIN_BUSY = 8'h90;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fcb_io_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] index;
    logic [7:0] wdata;
  } fcb_cfg_req_t;

  typedef struct packed {
    logic [1:0] drive_sel_n;
    logic [1:0] motor_n;
    logic density_select_out;
    logic write_gate_n;
  } fcb_pins_t;

  typedef enum logic [1:0] {
    FCB_CMD_IDLE = 2'b01,
    FCB_CMD_BUSY = 2'b10
  } fcb_cmd_t;
endpackage

// ===== fcb_sync.sv
// two flip-flop synchroniser, one per pin bit
// assumes inputs come from pins outside the clock domain
`timescale 1ns/100ps
module fcb_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins in, synchronised out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  // reset to ones: the pins are active low and idle high
  // each bit keeps its own pair so no vector has two writers
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else begin
        meta_q <= pin[i];
        sync_q <= meta_q;
      end
    end
    assign sync[i] = sync_q;
  end
endmodule

// ===== test_fcb_bank.sv
// self-checking bench for the configuration bank and runtime window
// assumes the host model drives all bus strobes at the falling edge
`timescale 1ns/100ps
module test_fcb_bank
  import fcb_pkg::*;
;
  logic clk, rst, g1, g6, wgate_req, wp, dd;
  logic index_n_pin, track0_n_pin, wp_n_pin, dskchg_n_pin;
  logic io_rvalid, io_claim, cfg_rvalid, h;
  logic [7:0] io_rdata, cfg_rdata, q, t, e, d;
  fcb_io_req_t io_req;
  fcb_cfg_req_t cfg_req;
  fcb_pins_t pins_o, pins_oe;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] ix[9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75,
    8'hF0, 8'hF1};
  logic [7:0] rv[9] = '{8'h00, 8'h03, 8'hF2, 8'h06, 8'h03, 8'h02, 8'h04,
    8'h24, 8'h00};

  fcb_bank u_fcb_bank (.clk(clk), .rst(rst), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_claim(io_claim),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .global_config_one_en(g1), .global_config_six_en(g6),
    .wgate_req(wgate_req), .double_density_mode(dd),
    .write_protected(wp), .index_n_pin(index_n_pin),
    .track0_n_pin(track0_n_pin), .wp_n_pin(wp_n_pin),
    .dskchg_n_pin(dskchg_n_pin), .pins_o(pins_o), .pins_oe(pins_oe));

  fcb_host_model u_fcb_host_model (.clk(clk), .io_req(io_req),
    .cfg_req(cfg_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .io_claim(io_claim), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cw(input logic [7:0] i, d);
    logic [7:0] r;
    logic v;
    u_fcb_host_model.cfg_cyc(1'b1, i, d, r, v);
  endtask

  // a read that never answers ends the run at once
  task automatic cr(input logic [7:0] i, output logic [7:0] r);
    logic v;
    u_fcb_host_model.cfg_cyc(1'b0, i, 8'h00, r, v);
    if (v !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask

  // window at the reset base 3F0h
  task automatic iw(input logic [2:0] o, input logic [7:0] d);
    logic [7:0] r;
    logic c;
    u_fcb_host_model.io_cyc(1'b1, {13'h007E, o}, d, r, c);
  endtask

  task automatic ir(input logic [2:0] o, output logic [7:0] r,
      output logic c);
    u_fcb_host_model.io_cyc(1'b0, {13'h007E, o}, 8'h00, r, c);
  endtask

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // every configuration entry against its reset value
  task automatic reset_check();
    logic [7:0] r;
    for (int k = 0; k < 9; k++) begin
      cr(ix[k], r);
      chk("rst", r, rv[k]);
    end
  endtask

  // readback after writing v to entry k of the index list
  function automatic logic [7:0] cfg_exp(input int k, input logic [7:0] v);
    case (k)
      1: cfg_exp = v & 8'h07;
      2: cfg_exp = v & 8'hFA;
      4: cfg_exp = {6'h00, v[1], 1'b1};
      6: cfg_exp = 8'h04;
      default: cfg_exp = v;
    endcase
  endfunction

  // drive selects and motors, active low, from a digital output value
  function automatic logic [7:0] drive_exp(input logic [7:0] v);
    drive_exp = {4'h0, !(v[5] && v[0]), !(v[4] && !v[0]), ~v[5:4]};
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end

  initial begin
    rst = 1'b1;
    g1 = 1'b1;
    g6 = 1'b1;
    wgate_req = 1'b0;
    wp_n_pin = 1'b1;
    dskchg_n_pin = 1'b1;
    t = 8'($urandom(32'h0dd4));
    index_n_pin = 1'($urandom);
    track0_n_pin = 1'($urandom);
    repeat (8) @(negedge clk);
    rst = 1'b0;
    reset_check();
    ir(3'h3, q, h);
    chk("claim inactive", {7'h00, h}, 8'h00);
    cw(8'h30, 8'h01);
    t = 8'($urandom);
    iw(3'h3, t);
    ir(3'h3, q, h);
    chk("tape legacy", q, {6'h3F, t[1:0]});
    chk("claim active", {7'h00, h}, 8'h01);
    ir(3'h6, q, h);
    chk("unused offset", q, 8'hFF);
    ir(3'h0, q, h);
    chk("status a float", q | 8'h0F, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      iw(3'h2, d);
      ir(3'h2, q, h);
      chk("digital output", q, d);
      ir(3'h1, q, h);
      chk("status b", q, {4'hF, d[5:4], d[0], 1'b1});
      ir(3'h0, q, h);
      e = {4'hF, index_n_pin, track0_n_pin, wp_n_pin, d[0]};
      chk("status a", q, e);
      e = {4'h0, pins_o.drive_sel_n, pins_o.motor_n};
      chk("drive pins", e, drive_exp(d));
    end
    u_fcb_host_model.io_cyc(1'b0, 16'h03E8, 8'h00, q, h);
    chk("claim outside", {7'h00, h}, 8'h00);
    g6 = 1'b0;
    ir(3'h3, q, h);
    chk("claim global off", {7'h00, h}, 8'h00);
    g6 = 1'b1;
    cw(8'hF0, 8'h64);
    cw(8'hF1, 8'h09);
    for (int k = 0; k < 2; k++) begin
      iw(3'h2, k[7:0]);
      ir(3'h3, q, h);
      e = k ? 8'hE0 : 8'hD0;
      chk("tape enhanced", q, e | {6'h03, t[1:0]});
    end
    for (int k = 0; k < 4; k++) begin
      dskchg_n_pin = k[1];
      cw(8'hF0, k[0] ? 8'h20 : 8'h24);
      iw(3'h7, 8'h02);
      settle();
      ir(3'h7, q, h);
      e = k[0] ? {dskchg_n_pin, 7'h7D} : {!dskchg_n_pin, 7'h7F};
      chk("digital input", q, e);
    end
    for (int k = 0; k < 8; k++) begin
      cw(8'hF0, k[2] ? 8'h24 : 8'h04);
      iw(3'h7, {6'h00, k[1:0]});
      settle();
      e = {7'h00, (k[1:0] == 2'h0 || k[1:0] == 2'h3) == k[2]};
      chk("density", {7'h00, pins_o.density_select_out}, e);
    end
    wgate_req = 1'b1;
    for (int k = 0; k < 3; k++) begin
      wp_n_pin = (k != 2);
      cw(8'hF0, (k == 1) ? 8'h2C : 8'h24);
      settle();
      e = (k != 0) ? 8'h03 : 8'h00;
      chk("protect", {6'h00, wp, pins_o.write_gate_n}, e);
    end
    wgate_req = 1'b0;
    iw(3'h2, 8'h04);
    iw(3'h5, 8'h40);
    settle();
    chk("mode", {7'h00, dd}, 8'h01);
    ir(3'h4, q, h);
    chk("main busy", q, FCB_MAIN_BUSY);
    ir(3'h5, q, h);
    ir(3'h4, q, h);
    chk("main idle", q, FCB_MAIN_READY);
    iw(3'h5, 8'h00);
    settle();
    chk("mode", {7'h00, dd}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      cw(8'hF0, (k == 2) ? 8'h24 : 8'h25);
      cw(8'h30, {7'h00, k[0]});
      settle();
      // only the first pass floats: float enabled and not activated
      e = (k == 0) ? 8'h00 : 8'h3F;
      chk("pin enables", {2'b00, pins_oe}, e);
    end
    for (int k = 1; k < 9; k++) begin
      t = 8'($urandom);
      e = (k == 7) ? t & 8'h6F : (k == 8) ? t & 8'h0F : t;
      cw(ix[k], e);
      cr(ix[k], q);
      e = cfg_exp(k, e);
      chk("cfg write", q, e);
    end
    // a second reset in mid-run must restore every written entry
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    reset_check();
    results();
  end
endmodule
